// ==== ecpm_pkg.sv ====
// constants shared by the configuration preload loader and its mapper
// assumes a 16-bit word serial memory image and a 12-bit config offset space
package ecpm_pkg;

    // ************************************************************
    // image layout (word indices; the read byte address is twice the index)
    // ************************************************************
    localparam logic [15:0] ECPM_SIGNATURE   = 16'h1516;
    localparam logic [7:0]  ECPM_EE_SIG_ADDR = 8'h00;
    localparam logic [2:0]  ECPM_W_SIG       = 3'h0;
    localparam logic [2:0]  ECPM_W_VID       = 3'h1;
    localparam logic [2:0]  ECPM_W_DID       = 3'h2;
    localparam logic [2:0]  ECPM_W_CAP       = 3'h3;
    localparam logic [2:0]  ECPM_W_SSVID     = 3'h4;
    localparam logic [2:0]  ECPM_W_SSID      = 3'h5;
    localparam logic [2:0]  ECPM_W_MISC      = 3'h6;
    localparam logic [2:0]  ECPM_W_LAST      = 3'h6;

    // ************************************************************
    // port range
    // ************************************************************
    localparam logic [2:0]  ECPM_PORT_UP     = 3'h0;
    localparam logic [2:0]  ECPM_PORT_LAST   = 3'h5;

    // ************************************************************
    // configuration offsets
    // ************************************************************
    localparam logic [11:0] ECPM_OFF_ID      = 12'h000;
    localparam logic [11:0] ECPM_OFF_SSID    = 12'h0B4;
    localparam logic [11:0] ECPM_OFF_VC      = 12'h144;
    localparam logic [11:0] ECPM_OFF_LINK    = 12'h0CC;
    localparam logic [11:0] ECPM_OFF_SWMODE  = 12'h074;
    localparam logic [11:0] ECPM_OFF_DEVCAP  = 12'h0C4;
    localparam logic [11:0] ECPM_OFF_CAPDIS  = 12'h070;
    localparam logic [11:0] ECPM_OFF_TLCSR   = 12'h08C;

    // ************************************************************
    // field positions in configuration registers
    // ************************************************************
    localparam int ECPM_B_VC       = 0;
    localparam int ECPM_B_L0S      = 12;
    localparam int ECPM_B_L1       = 15;
    localparam int ECPM_B_CLKPM    = 18;
    localparam int ECPM_B_SF       = 0;
    localparam int ECPM_B_CTTH     = 1;
    localparam int ECPM_B_ARB      = 3;
    localparam int ECPM_B_CRED     = 4;
    localparam int ECPM_B_NOEGR    = 5;
    localparam int ECPM_B_NOTAG    = 6;
    localparam int ECPM_B_NPSF     = 7;
    localparam int ECPM_B_PARDIS   = 15;
    localparam int ECPM_B_MPS      = 0;
    localparam int ECPM_B_RBER     = 15;
    localparam int ECPM_B_ASPM     = 10;
    localparam int ECPM_B_LBN      = 21;
    localparam int ECPM_B_PMDIS    = 13;
    localparam int ECPM_B_MSIDIS   = 14;
    localparam int ECPM_B_SOFLAT   = 0;
    localparam int ECPM_B_PPNP     = 5;
    localparam int ECPM_B_FROZEN   = 6;

    localparam logic [31:0] ECPM_M_LO16    = 32'h0000FFFF;
    localparam logic [31:0] ECPM_M_HI16    = 32'hFFFF0000;
    localparam logic [31:0] ECPM_M_VC      = 32'h00000001;
    localparam logic [31:0] ECPM_M_LINKCAP = 32'h0007F000;
    localparam logic [31:0] ECPM_M_SWMODE  = 32'h000000FF;
    localparam logic [31:0] ECPM_M_DEVCAP  = 32'h00008003;
    localparam logic [31:0] ECPM_M_ASPM    = 32'h00000C00;
    localparam logic [31:0] ECPM_M_LBN     = 32'h00200000;
    localparam logic [31:0] ECPM_M_CAPDIS  = 32'h00006000;
    localparam logic [31:0] ECPM_M_PARDIS  = 32'h00008000;
    localparam logic [31:0] ECPM_M_TLCSR   = 32'h00000061;

    // ************************************************************
    // software registers and fields
    // ************************************************************
    localparam logic [7:0]  ECPM_REG_CTRL    = 8'h00;
    localparam logic [7:0]  ECPM_REG_STATUS  = 8'h04;
    localparam logic [7:0]  ECPM_REG_SIGWORD = 8'h08;
    localparam int          ECPM_CTRL_RELOAD = 0;
    localparam int          ECPM_ST_BUSY     = 0;
    localparam int          ECPM_ST_DONE     = 1;
    localparam int          ECPM_ST_SIGOK    = 2;
    localparam int          ECPM_ST_SIGBAD   = 3;

endpackage : ecpm_pkg

// ==== ecpm_mapper.sv ====
// image word to configuration write mapping, purely combinational
// assumes the caller walks slot and port and keeps word data stable
`timescale 1ns/1ps
module ecpm_mapper
    import ecpm_pkg::*;
(
    input  wire logic [2:0]  word_sel,
    input  wire logic [2:0]  port_idx,
    input  wire logic [2:0]  slot,
    input  wire logic [15:0] word_data,
    output logic             hit,
    output logic             last_slot,
    output logic [11:0]      offset,
    output logic [31:0]      data,
    output logic [31:0]      mask
);

    // ************************************************************
    // decode
    // ************************************************************
    wire logic        up_port = (port_idx == ECPM_PORT_UP);
    wire logic [15:0] d       = word_data;
    wire logic [31:0] cap_cc  = {13'h0, d[7], d[6:4], d[3:1], 12'h0};
    wire logic [31:0] cap_74  = {24'h0, d[15], d[9], d[8], d[14],
                                 d[13], d[12:11], d[10]};
    wire logic [31:0] msc_c4  = {16'h0, d[4], 13'h0, d[1:0]};
    wire logic [31:0] msc_cc  = {10'h0, d[9], 9'h0, d[3:2], 10'h0};
    wire logic [31:0] msc_70  = {17'h0, d[5], d[7], 13'h0};
    wire logic [31:0] msc_74  = {16'h0, d[6], 15'h0};
    wire logic [31:0] msc_8c  = {25'h0, d[10], d[8], 4'h0, d[11]};
    wire logic [31:0] lbn_m   = up_port ? 32'h0 : ECPM_M_LBN;

    always_comb begin
        hit       = 1'b0;
        last_slot = 1'b1;
        offset    = 12'h000;
        data      = 32'h0;
        mask      = 32'h0;
        case (word_sel)
            ECPM_W_VID, ECPM_W_DID: begin
                // identity fields live only in the upstream function
                hit    = up_port && (slot == 3'h0);
                offset = ECPM_OFF_ID;
                data   = {d, d};
                mask   = (word_sel == ECPM_W_VID) ? ECPM_M_LO16
                                                  : ECPM_M_HI16;
            end
            ECPM_W_SSVID, ECPM_W_SSID: begin
                hit    = up_port && (slot == 3'h0);
                offset = ECPM_OFF_SSID;
                data   = {d, d};
                mask   = (word_sel == ECPM_W_SSVID) ? ECPM_M_LO16
                                                    : ECPM_M_HI16;
            end
            ECPM_W_CAP: begin
                last_slot = (slot == 3'h2);
                case (slot)
                    3'h0: begin
                        hit    = 1'b1;
                        offset = ECPM_OFF_VC;
                        data   = {31'h0, d[0]};
                        mask   = ECPM_M_VC;
                    end
                    3'h1: begin
                        hit    = 1'b1;
                        offset = ECPM_OFF_LINK;
                        data   = cap_cc;
                        mask   = ECPM_M_LINKCAP;
                    end
                    3'h2: begin
                        hit    = up_port;
                        offset = ECPM_OFF_SWMODE;
                        data   = cap_74;
                        mask   = ECPM_M_SWMODE;
                    end
                    default: begin
                        hit = 1'b0;
                    end
                endcase
            end
            ECPM_W_MISC: begin
                last_slot = (slot == 3'h4);
                hit       = (slot <= 3'h4);
                case (slot)
                    3'h0: begin
                        offset = ECPM_OFF_DEVCAP;
                        data   = msc_c4;
                        mask   = ECPM_M_DEVCAP;
                    end
                    3'h1: begin
                        offset = ECPM_OFF_LINK;
                        data   = msc_cc;
                        mask   = ECPM_M_ASPM | lbn_m;
                    end
                    3'h2: begin
                        offset = ECPM_OFF_CAPDIS;
                        data   = msc_70;
                        mask   = ECPM_M_CAPDIS;
                    end
                    3'h3: begin
                        offset = ECPM_OFF_SWMODE;
                        data   = msc_74;
                        mask   = ECPM_M_PARDIS;
                    end
                    default: begin
                        offset = ECPM_OFF_TLCSR;
                        data   = msc_8c;
                        mask   = ECPM_M_TLCSR;
                    end
                endcase
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

endmodule : ecpm_mapper

// ==== ecpm_loader.sv ====
// configuration preload loader: reads the image, checks it, writes config
// assumes memory answers each read with one ee_valid pulse, config never stalls
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps
module ecpm_loader
    import ecpm_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata_reg,
    output logic             ee_req_reg,
    output logic [7:0]       ee_addr_reg,
    input  wire logic [15:0] ee_data,
    input  wire logic        ee_valid,
    output logic             cfg_wr_reg,
    output logic [2:0]       cfg_port_reg,
    output logic [11:0]      cfg_offset_reg,
    output logic [31:0]      cfg_data_reg,
    output logic [31:0]      cfg_mask_reg,
    output logic             load_done_reg
);

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_SIG_REQ  = 3'h1,
        ST_SIG_WAIT = 3'h3,
        ST_WRD_REQ  = 3'h2,
        ST_WRD_WAIT = 3'h6,
        ST_EMIT     = 3'h7,
        ST_DONE     = 3'h5
    } ecpm_state_e;

    ecpm_state_e state_reg;
    ecpm_state_e state_next;
    logic        pend_reg;
    logic [2:0]  word_reg;
    logic [2:0]  word_next;
    logic [2:0]  port_reg;
    logic [2:0]  port_next;
    logic [2:0]  slot_reg;
    logic [2:0]  slot_next;
    logic [15:0] wdat_reg;
    logic [15:0] sig_word_reg;
    logic        sig_ok_reg;
    logic        sig_bad_reg;
    logic        map_hit;
    logic        map_last;
    logic [11:0] map_off;
    logic [31:0] map_data;
    logic [31:0] map_mask;

    // ************************************************************
    // register decode
    // ************************************************************
    wire logic idle_now   = (state_reg == ST_IDLE) || (state_reg == ST_DONE);
    wire logic wr_ctrl    = reg_wr && (reg_addr == ECPM_REG_CTRL);
    // reload while busy is dropped: a half-written image cannot restart
    wire logic reload_req = wr_ctrl && reg_wdata[ECPM_CTRL_RELOAD];
    wire logic start      = pend_reg && (state_reg == ST_IDLE);
    wire logic sig_match  = (ee_data == ECPM_SIGNATURE);
    wire logic sig_seen   = (state_reg == ST_SIG_WAIT) && ee_valid;
    wire logic emit_now   = (state_reg == ST_EMIT);
    wire logic port_end   = map_last && (port_reg == ECPM_PORT_LAST);
    wire logic word_end   = port_end && (word_reg == ECPM_W_LAST);
    wire logic [31:0] status_word = {28'h0, sig_bad_reg, sig_ok_reg,
                                     load_done_reg, !idle_now};
    wire logic [31:0] rd_mux =
        (reg_addr == ECPM_REG_CTRL)    ? 32'h0 :
        (reg_addr == ECPM_REG_STATUS)  ? status_word :
        (reg_addr == ECPM_REG_SIGWORD) ? {16'h0, sig_word_reg} : 32'h0;

    // ************************************************************
    // mapping of the current word, port and slot
    // ************************************************************
    ecpm_mapper u_map (
        .word_sel  (word_reg),
        .port_idx  (port_reg),
        .slot      (slot_reg),
        .word_data (wdat_reg),
        .hit       (map_hit),
        .last_slot (map_last),
        .offset    (map_off),
        .data      (map_data),
        .mask      (map_mask)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        word_next  = word_reg;
        port_next  = port_reg;
        slot_next  = slot_reg;
        case (state_reg)
            ST_IDLE: begin
                if (pend_reg) begin
                    state_next = ST_SIG_REQ;
                end
            end
            ST_SIG_REQ: begin
                state_next = ST_SIG_WAIT;
            end
            ST_SIG_WAIT: begin
                if (ee_valid) begin
                    // mismatch jumps to done: nothing is written
                    state_next = sig_match ? ST_WRD_REQ : ST_DONE;
                    word_next  = ECPM_W_VID;
                end
            end
            ST_WRD_REQ: begin
                state_next = ST_WRD_WAIT;
            end
            ST_WRD_WAIT: begin
                if (ee_valid) begin
                    state_next = ST_EMIT;
                    port_next  = ECPM_PORT_UP;
                    slot_next  = 3'h0;
                end
            end
            ST_EMIT: begin
                if (!map_last) begin
                    slot_next = slot_reg + 3'h1;
                end else if (!port_end) begin
                    slot_next = 3'h0;
                    port_next = port_reg + 3'h1;
                end else if (!word_end) begin
                    word_next  = word_reg + 3'h1;
                    state_next = ST_WRD_REQ;
                end else begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            word_reg  <= ECPM_W_SIG;
            port_reg  <= 3'h0;
            slot_reg  <= 3'h0;
        end else begin
            state_reg <= state_next;
            word_reg  <= word_next;
            port_reg  <= port_next;
            slot_reg  <= slot_next;
        end
    end

    // ************************************************************
    // start request and status flags
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg <= 1'b1;
        end else if (start) begin
            pend_reg <= 1'b0;
        end else if (reload_req && idle_now) begin
            pend_reg <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sig_ok_reg    <= 1'b0;
            sig_bad_reg   <= 1'b0;
            load_done_reg <= 1'b0;
            sig_word_reg  <= 16'h0;
        end else if (start) begin
            sig_ok_reg    <= 1'b0;
            sig_bad_reg   <= 1'b0;
            load_done_reg <= 1'b0;
        end else begin
            if (sig_seen) begin
                sig_word_reg <= ee_data;
                sig_ok_reg   <= sig_match;
                sig_bad_reg  <= !sig_match;
            end
            if (state_reg == ST_DONE) begin
                load_done_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // image memory reads
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ee_req_reg  <= 1'b0;
            ee_addr_reg <= 8'h00;
            wdat_reg    <= 16'h0;
        end else begin
            ee_req_reg <= (state_next == ST_SIG_REQ)
                       || (state_next == ST_WRD_REQ);
            if (state_next == ST_SIG_REQ) begin
                ee_addr_reg <= ECPM_EE_SIG_ADDR;
            end else if (state_next == ST_WRD_REQ) begin
                ee_addr_reg <= {4'h0, word_next, 1'b0};
            end
            if ((state_reg == ST_WRD_WAIT) && ee_valid) begin
                wdat_reg <= ee_data;
            end
        end
    end

    // ************************************************************
    // configuration writes
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_wr_reg     <= 1'b0;
            cfg_port_reg   <= 3'h0;
            cfg_offset_reg <= 12'h000;
            cfg_data_reg   <= 32'h0;
            cfg_mask_reg   <= 32'h0;
        end else begin
            cfg_wr_reg <= emit_now && map_hit && sig_ok_reg;
            if (emit_now) begin
                cfg_port_reg   <= port_reg;
                cfg_offset_reg <= map_off;
                cfg_data_reg   <= map_data & map_mask;
                cfg_mask_reg   <= map_mask;
            end
        end
    end

    // ************************************************************
    // register read port
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_reg <= 32'h0;
        end else begin
            reg_rdata_reg <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_bad_sig_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sig_seen && !sig_match |=> state_reg == ST_DONE ##1 load_done_reg)
        else $error("bad signature did not end the load");
    a_no_write_bad: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg |-> sig_ok_reg && !sig_bad_reg)
        else $error("config write without valid signature");
    a_id_port_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg && (cfg_offset_reg == ECPM_OFF_ID
                       || cfg_offset_reg == ECPM_OFF_SSID)
        |-> cfg_port_reg == ECPM_PORT_UP
            && (cfg_mask_reg == ECPM_M_LO16 || cfg_mask_reg == ECPM_M_HI16)
            && cfg_data_reg == ({wdat_reg, wdat_reg} & cfg_mask_reg))
        else $error("identifier write to wrong port");
    a_vc_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg && cfg_offset_reg == ECPM_OFF_VC
        |-> cfg_mask_reg == ECPM_M_VC && cfg_data_reg[0] == wdat_reg[0])
        else $error("extended channel count mis-loaded");
    a_link_latency: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg && cfg_offset_reg == ECPM_OFF_LINK
        && word_reg == ECPM_W_CAP
        |-> cfg_data_reg[17:12] == {wdat_reg[6:4], wdat_reg[3:1]}
            && cfg_data_reg[18] == wdat_reg[7])
        else $error("exit latency fields mis-loaded");
    a_swmode_port0: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg && cfg_mask_reg == ECPM_M_SWMODE
        |-> cfg_port_reg == ECPM_PORT_UP
            && cfg_data_reg[7:0] == {wdat_reg[15], wdat_reg[9:8],
                                     wdat_reg[14:13], wdat_reg[12:10]})
        else $error("switch mode written off port 0");
    a_payload_rber: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg && cfg_offset_reg == ECPM_OFF_DEVCAP
        |-> cfg_data_reg[1:0] == wdat_reg[1:0]
            && cfg_data_reg[15] == wdat_reg[4])
        else $error("payload or error reporting mis-loaded");
    a_bw_notify: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg && word_reg == ECPM_W_MISC
        && cfg_offset_reg == ECPM_OFF_LINK
        |-> cfg_mask_reg[21] == (cfg_port_reg != ECPM_PORT_UP))
        else $error("bandwidth notification port range wrong");
    a_order_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg && cfg_offset_reg == ECPM_OFF_TLCSR
        |-> cfg_data_reg[6:5] == {wdat_reg[10], wdat_reg[8]}
            && cfg_data_reg[0] == wdat_reg[11])
        else $error("ordering controls mis-loaded");
    a_req_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ee_req_reg |=> !ee_req_reg)
        else $error("memory request longer than one cycle");
    a_ee_addr_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ee_req_reg |-> ee_addr_reg[7:4] == 4'h0 && !ee_addr_reg[0]
            && ee_addr_reg[3:1] <= ECPM_W_LAST)
        else $error("image read outside the image");
    a_aspm_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg && word_reg == ECPM_W_MISC
        && cfg_offset_reg == ECPM_OFF_LINK
        |-> cfg_data_reg[11:10] == wdat_reg[3:2]
            && cfg_data_reg[21] == (wdat_reg[9]
                                    && cfg_port_reg != ECPM_PORT_UP))
        else $error("link power levels mis-loaded");
    a_capdis_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg && cfg_offset_reg == ECPM_OFF_CAPDIS
        |-> cfg_data_reg[14:13] == {wdat_reg[5], wdat_reg[7]})
        else $error("capability disable bits mis-loaded");
    a_pardis_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cfg_wr_reg && cfg_mask_reg == ECPM_M_PARDIS
        |-> cfg_offset_reg == ECPM_OFF_SWMODE
            && cfg_data_reg[15] == wdat_reg[6])
        else $error("compliance parity disable mis-loaded");
    // a restart mid-image would mix two images in config space
    a_reload_busy: assert property (@(posedge ref_clk) disable iff (!rst_n)
        reload_req && !idle_now |=> !pend_reg)
        else $error("reload accepted while busy");
    a_start_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
        start |=> !load_done_reg && !sig_ok_reg && !sig_bad_reg)
        else $error("status flags not cleared at start");
    a_sig_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sig_ok_reg |-> !sig_bad_reg)
        else $error("signature good and bad together");
    a_rdata_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata_reg == 32'h0)
        else $error("read data without a read strobe");

endmodule : ecpm_loader

// ==== ecpm_ee_model.sv ====
// image memory model answering one loader word read at a time
// assumes the loader keeps one read outstanding; lat sets answer delay
`timescale 1ns/1ps
module ecpm_ee_model (
    input  wire logic       ref_clk,
    input  wire logic       ee_req,
    input  wire logic [7:0] ee_addr,
    input  wire logic [3:0] lat,
    output logic [15:0]     ee_data,
    output logic            ee_valid
);
    logic [15:0] img [0:6]; // word 0 carries the signature
    initial begin
        ee_valid = 1'b0;
        ee_data  = 16'h5A5A;
        forever begin
            @(posedge ref_clk);
            if (ee_req === 1'b1) begin
                repeat (lat) @(posedge ref_clk);
                ee_valid <= 1'b1;
                ee_data  <= img[ee_addr[3:1]];
                @(posedge ref_clk);
                ee_valid <= 1'b0;
                // inverted so stale data never looks valid
                ee_data  <= ~img[ee_addr[3:1]];
            end
        end
    end
endmodule : ecpm_ee_model

// ==== ecpm_tb_top.sv ====
// self-checking bench: loader, memory model, shadow config space
// assumes config writes are never stalled and apply under their mask
`timescale 1ns/1ps
module ecpm_tb_top;
    import ecpm_pkg::*;
    logic        ref_clk, rst_n, reg_wr, reg_rd, ee_valid, ee_req_reg;
    logic        cfg_wr_reg, load_done_reg, good;
    logic [3:0]  lat;
    logic [7:0]  reg_addr, ee_addr_reg;
    logic [15:0] ee_data, im [0:6];
    logic [2:0]  cfg_port_reg;
    logic [11:0] cfg_offset_reg, offs [0:7];
    logic [31:0] reg_wdata, reg_rdata_reg, cfg_data_reg, cfg_mask_reg, v, d;
    logic [31:0] cs [0:5][0:1023];
    logic [31:0] seed = 32'd88;
    int          err_count = 0, checked = 0, i, k, p, t;
    ecpm_loader i_dut (.*);
    ecpm_ee_model i_ee (.ref_clk(ref_clk), .ee_req(ee_req_reg),
        .ee_addr(ee_addr_reg), .lat(lat), .ee_data(ee_data),
        .ee_valid(ee_valid));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
        if (cfg_wr_reg === 1'b1)
            cs[cfg_port_reg][cfg_offset_reg[11:2]] <= (cfg_data_reg &
                cfg_mask_reg) | (cs[cfg_port_reg][cfg_offset_reg[11:2]] &
                ~cfg_mask_reg);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] exp_val(int p, int k);
        logic [15:0] c, m;
        c = im[3];
        m = im[6];
        case (k)
            0: return (p == 0) ? {im[2], im[1]} : 32'h0;
            1: return (p == 0) ? {im[5], im[4]} : 32'h0;
            2: return {31'h0, c[0]};
            3: return {10'h0, m[9] & (p != 0), 2'h0, c[7:1], m[3:2],
                10'h0};
            4: return {16'h0, m[6], 7'h0, (p == 0) ? {c[15], c[9:8],
                c[14:13], c[12:11], c[10]} : 8'h0};
            5: return {16'h0, m[4], 13'h0, m[1:0]};
            6: return {17'h0, m[5], m[7], 13'h0};
            default: return {25'h0, m[10], m[8], 4'h0, m[11]};
        endcase
    endfunction : exp_val
    task automatic chk(logic [31:0] got, logic [31:0] ex);
        checked++;
        if (got !== ex) begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h", $time, got, ex);
        end
    endtask : chk
    task automatic rd_reg(logic [7:0] a, output logic [31:0] q);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 q = reg_rdata_reg;
    endtask : rd_reg
    task automatic wr_reg(logic [7:0] a, logic [31:0] w);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= w;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr_reg
    task automatic final_report();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, lat} = '0;
        offs = '{12'h000, 12'h0B4, 12'h144, 12'h0CC, 12'h074, 12'h0C4,
            12'h070, 12'h08C};
        for (t = 0; t < 3; t++) begin
            good = (t != 1);
            for (k = 0; k < 7; k++) begin
                v = rnd();
                im[k] = v[15:0];
            end
            // bad word flips at least bit 0, corner of the compare
            im[0] = good ? ECPM_SIGNATURE : ECPM_SIGNATURE ^ (v[15:0] | 16'h1);
            for (k = 0; k < 7; k++) i_ee.img[k] = im[k];
            lat <= v[19:16];
            for (p = 0; p < 6; p++) for (k = 0; k < 8; k++)
                cs[p][offs[k][11:2]] = 32'h0;
            if (t == 0) begin
                repeat (5) @(posedge ref_clk);
                rst_n <= 1'b1;
            end else begin
                wr_reg(ECPM_REG_CTRL, 32'h1);
            end
            for (i = 0; i < 3000 && ee_req_reg !== 1'b1; i++) @(posedge ref_clk);
            // reload while busy must be dropped, status shows it
            if (t == 2) wr_reg(ECPM_REG_CTRL, 32'h1);
            for (; i < 3000 && load_done_reg !== 1'b1; i++) @(posedge ref_clk);
            if (i >= 3000) begin
                err_count++;
                final_report();
            end
            @(posedge ref_clk);
            for (p = 0; p < 6; p++) for (k = 0; k < 8; k++)
                chk(cs[p][offs[k][11:2]], good ? exp_val(p, k) : 32'h0);
            rd_reg(ECPM_REG_STATUS, d);
            chk(d, good ? 32'h6 : 32'hA);
            rd_reg(ECPM_REG_SIGWORD, d);
            chk(d & 32'hFFFF, {16'h0, im[0]});
            rd_reg(8'h0C, d);
            chk(d, 32'h0);
            rd_reg(ECPM_REG_CTRL, d);
            chk(d, 32'h0);
            $display("test %0d done", t);
        end
        final_report();
    end
endmodule : ecpm_tb_top
